// ### dv/scc_dma_host.sv
// scc_dma_host: dma controller model that serves the channel's transmit requests
`timescale 1ns/1ps
module scc_dma_host (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // dma handshake and pacing
    input wire logic req_i,
    input wire logic [3:0] gap_i,
    output logic ack_o,
    // served bytes, for the bench
    output logic [15:0] acks_o
);
    logic [3:0] wait_q;

    // one ack per request seen, then gap_i plus one idle cycles as a busy system bus would leave
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            wait_q <= 4'h0;
        end
        else
        begin
            ack_o <= req_i && !ack_o && (wait_q == 4'h0);
            wait_q <= ack_o ? gap_i : ((wait_q != 4'h0) ? wait_q - 4'h1 : 4'h0);
        end
    end

    // count every byte handed over
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            acks_o <= 16'h0000;
        else
            acks_o <= acks_o + {15'h0000, ack_o};
    end
endmodule : scc_dma_host

// ### dv/tb_serial_channel_count_config_regs.sv
// tb_serial_channel_count_config_regs: self-checking bench of the channel register bank
`timescale 1ns/1ps
module tb_serial_channel_count_config_regs;
    import scc_pkg::*;
    logic clk;
    logic rst;
    scc_bus_req_s bus;
    logic rx_byte;
    logic [4:0] ev;
    logic carrier;
    logic txe;
    logic auto_mode;
    logic dma_ack;
    logic [3:0] gap;
    logic [7:0] rdata;
    logic dma_req;
    scc_line_s line;
    logic pwr, dmam, hdx, mclk, rxen, cgp, bdly, rpt, ffill, sev;
    logic [15:0] acks;
    int num_errors = 0;
    int checks = 0;
    int sevs = 0;
    int base;

    // design under test; loop release needs an empty tx fifo and the closing flag
    scc_regs i_scc_regs (
        .core_clk_i(clk), .rst_i(rst), .bus_i(bus), .rdata_o(rdata),
        .rx_byte_i(rx_byte), .rx_frame_end_i(ev[0]), .end_of_poll_i(ev[1]),
        .carrier_detect_input_i(carrier), .auto_mode_i(auto_mode),
        .transmit_frame_cmd_i(ev[2]), .transmit_iframe_cmd_i(ev[3]),
        .tx_fifo_empty_i(txe), .closing_flag_sent_i(ev[4]),
        .dma_ack_i(dma_ack), .dma_req_o(dma_req), .line_o(line), .power_up_o(pwr),
        .dma_mode_o(dmam), .half_duplex_o(hdx), .master_clock_o(mclk),
        .rx_enable_o(rxen), .carrier_gp_o(cgp), .loop_bit_delay_o(bdly),
        .loop_repeat_o(rpt), .loop_flag_fill_o(ffill), .seventh_one_zero_o(sev)
    );

    // far side dma controller
    scc_dma_host i_scc_dma_host (
        .core_clk_i(clk), .rst_i(rst), .req_i(dma_req), .gap_i(gap),
        .ack_o(dma_ack), .acks_o(acks)
    );

    // 40 mhz core clock
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // flag-forming pulses are one cycle, so count them as they pass
    always @(posedge clk)
        if (sev === 1'b1)
            sevs++;

    task chk(input logic [15:0] s, input logic [15:0] e);
        checks++;
        if (s !== e)
        begin
            num_errors++;
            $display("ERROR time=%0t seen=%h expected=%h", $time, s, e);
        end
    endtask : chk

    task results;
        $display("checks=%0d errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results

    // write takes effect at the strobe edge; the #1 lets decoded outputs settle
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clk);
        bus.wr <= 1'b0;
        #1;
    endtask : wr

    // read data stands only in the cycle after the strobe
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk);
        bus.rd <= 1'b0;
        #1;
        chk(16'(rdata), 16'(e));
    endtask : rd

    task pulse(input int b);
        @(posedge clk);
        ev <= 5'h01 << b;
        @(posedge clk);
        ev <= 5'h00;
        #1;
    endtask : pulse

    task frame(input int n);
        @(posedge clk);
        rx_byte <= 1'b1;
        repeat (n) @(posedge clk);
        rx_byte <= 1'b0;
        pulse(0);
    endtask : frame

    task lvl(input logic c, input logic a);
        @(posedge clk);
        carrier <= c;
        auto_mode <= a;
        repeat (4) @(posedge clk);
        #1;
    endtask : lvl

    // program a length, issue a frame command, wait for requests to stop, count bytes
    task dma_frame(input logic [7:0] hi, input logic [7:0] lo, input int cmd, input int e);
        int i;
        wr(8'h2b, hi);
        wr(8'h2a, lo);
        base = acks;
        pulse(cmd);
        i = 0;
        while (dma_req === 1'b1 && i < 20000)
        begin
            @(posedge clk);
            #1;
            i++;
        end
        if (i == 20000)
        begin
            num_errors++;
            results;
        end
        chk(acks - 16'(base), 16'(e));
    endtask : dma_frame

    initial
    begin
        rst = 1'b1;
        bus = '0;
        rx_byte = 1'b0;
        ev = 5'h00;
        carrier = 1'b0;
        txe = 1'b1;
        auto_mode = 1'b0;
        gap = 4'h0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd(8'h2c, CFG_RESET);
        rd(8'h2d, 8'h00);
        rd(8'h2e, 8'h00);
        rd(8'h2b, 8'h00);
        rd(8'h30, READ_UNMAPPED);
        chk(16'(pwr), 16'h0);
        $display("test reset done");
        wr(8'h2c, 8'hff);
        wr(8'h30, 8'h00);
        rd(8'h2c, CFG0_WRITABLE);
        for (int p = 0; p < 8; p++)
        begin
            wr(8'h2c, 8'h80 | 8'(p << 2));
            chk(16'(line.port), 16'(p));
            chk(16'(line.bus_mode), 16'(p == 1 || p == 3));
            chk(16'(pwr), 16'h1);
            if (p == 1 || p == 3)
                chk(16'(line.nrz_only), 16'h1);
        end
        for (int m = 0; m < 4; m++)
        begin
            wr(8'h2c, 8'(m));
            chk(16'(line.smode), 16'(m));
            chk(16'(pwr), 16'h0);
        end
        wr(8'h2d, 8'h00);
        wr(8'h2c, 8'hc0);
        chk(16'(mclk), 16'h1);
        wr(8'h2d, 8'h05);
        chk(16'(mclk), 16'h0);
        wr(8'h2d, 8'h00);
        wr(8'h2c, 8'hc1);
        chk(16'(mclk), 16'h0);
        $display("test config zero done");
        wr(8'h2c, 8'h80);
        wr(8'h2d, 8'h9f);
        rd(8'h2d, 8'h9f);
        chk(16'(line.shared_flag), 16'h1);
        chk(16'(line.idle_flags), 16'h1);
        chk(16'(line.one_insert), 16'h0);
        chk(16'(line.clk_mode), 16'h7);
        chk(16'(line.push_pull), 16'h1);
        wr(8'h2d, 8'h00);
        chk(16'(line.push_pull), 16'h0);
        chk(16'(line.idle_flags), 16'h0);
        chk(16'(line.shared_flag), 16'h0);
        wr(8'h2c, 8'h84);
        wr(8'h2d, 8'h08);
        chk(16'(line.idle_flags), 16'h0);
        chk(16'(line.one_insert), 16'h1);
        wr(8'h2c, 8'hc4);
        chk(16'(line.one_insert), 16'h0);
        wr(8'h2e, 8'ha5);
        rd(8'h2e, 8'ha5);
        $display("test config one and two done");
        frame(3);
        rd(8'h2a, 8'h03);
        rd(8'h2b, 8'h00);
        frame(4095);
        rd(8'h2a, 8'hff);
        rd(8'h2b, 8'h0f);
        frame(4096);
        rd(8'h2a, 8'h00);
        rd(8'h2b, 8'h10);
        frame(37);
        rd(8'h2a, 8'h25);
        rd(8'h2b, 8'h00);
        $display("test receive count done");
        wr(8'h2b, 8'hf0);
        rd(8'h2b, 8'he0);
        chk(16'(dmam), 16'h1);
        lvl(1'b0, 1'b1);
        chk(16'(hdx), 16'h1);
        lvl(1'b0, 1'b0);
        chk(16'(hdx), 16'h0);
        wr(8'h2c, 8'h80);
        wr(8'h2d, 8'h00);
        chk(16'(rxen), 16'h0);
        lvl(1'b1, 1'b0);
        chk(16'(rxen), 16'h1);
        chk(16'(cgp), 16'h0);
        wr(8'h2b, 8'h00);
        chk(16'(cgp), 16'h1);
        wr(8'h2d, 8'h01);
        chk(16'(cgp), 16'h0);
        wr(8'h2d, 8'h00);
        $display("test mode bits done");
        dma_frame(8'h80, 8'h02, 2, 3);
        dma_frame(8'h80, 8'h00, 3, 1);
        dma_frame(8'h8f, 8'hff, 2, 4096);
        gap = 4'h3;
        dma_frame(8'h80, 8'h10, 3, 17);
        gap = 4'h0;
        wr(8'h2b, 8'h90);
        wr(8'h2a, 8'h01);
        chk(16'(dma_req), 16'h0);
        base = acks;
        pulse(2);
        repeat (40) @(posedge clk);
        #1;
        chk(16'(dma_req), 16'h1);
        chk(16'(acks - 16'(base) > 16'h4), 16'h1);
        wr(8'h2b, 8'h00);
        pulse(2);
        chk(16'(dma_req), 16'h0);
        $display("test dma done");
        wr(8'h2c, 8'h81);
        wr(8'h2d, 8'h20);
        pulse(1);
        chk(16'(bdly), 16'h1);
        wr(8'h2d, 8'h60);
        pulse(1);
        repeat (3) @(posedge clk);
        #1;
        chk(16'(sevs), 16'h1);
        chk(16'(ffill), 16'h1);
        wr(8'h2d, 8'h20);
        txe <= 1'b0;
        pulse(4);
        chk(16'(ffill), 16'h1);
        txe <= 1'b1;
        pulse(4);
        chk(16'(ffill), 16'h0);
        chk(16'(rpt), 16'h1);
        wr(8'h2d, 8'h00);
        pulse(1);
        chk(16'(bdly), 16'h0);
        $display("test loop done");
        results;
    end
endmodule : tb_serial_channel_count_config_regs

// ### src/scc_dma_req.sv
// scc_dma_req: counts transmit dma requests for one frame
`timescale 1ns/1ps
module scc_dma_req #(
    parameter int CW = 12
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // control
    input wire logic enable_i,
    input wire logic start_i,
    input wire logic cont_i,
    input wire logic [CW-1:0] len_i,
    // dma handshake
    input wire logic ack_i,
    output logic req_o
);
    import scc_pkg::*;

    logic [CW:0] left_q;
    logic run_q;

    // request stays up while bytes are owed, or after a command in continuous mode;
    // setting continuous alone must not start a frame the host never asked for
    assign req_o = enable_i && ((cont_i && run_q) || (left_q != '0));

    // load length plus one on a frame command, count down on each ack in counted mode
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i || !enable_i)
        begin
            left_q <= '0;
        end
        else if (start_i)
        begin
            left_q <= {1'b0, len_i} + (CW+1)'(1);
        end
        else if (ack_i && !cont_i && (left_q != '0))
        begin
            left_q <= left_q - (CW+1)'(1);
        end
    end

    // a frame runs from its command until the count drains in counted mode
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i || !enable_i)
        begin
            run_q <= 1'b0;
        end
        else if (start_i)
        begin
            run_q <= 1'b1;
        end
        else if (!cont_i && (left_q == '0))
        begin
            run_q <= 1'b0;
        end
    end

    // a fresh command always owes the programmed length plus one
    dma_load_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (enable_i && start_i) |=> (left_q == {1'b0, $past(len_i)} + (CW+1)'(1)))
        else $error("dma request count not loaded with length plus one");

endmodule : scc_dma_req

// ### src/scc_pkg.sv
// scc_pkg: constants, codes and carriers of the serial channel count and config registers
package scc_pkg;

    // register addresses (low byte of the channel window)
    localparam logic [7:0] ADDR_BYTE_CNT_LOW = 8'h2a;
    localparam logic [7:0] ADDR_BYTE_CNT_HIGH = 8'h2b;
    localparam logic [7:0] ADDR_CFG_ZERO = 8'h2c;
    localparam logic [7:0] ADDR_CFG_ONE = 8'h2d;
    localparam logic [7:0] ADDR_CFG_TWO = 8'h2e;

    // reset values
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [2:0] MODE_BITS_RESET = 3'h0;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // byte count geometry
    localparam int CNT_W = 12;
    localparam int FIFO_CNT_W = 5;
    localparam logic [11:0] CNT_MAX = 12'hfff;

    // channel config zero fields
    localparam int CFG0_POWER_BIT = 7;
    localparam int CFG0_MCE_BIT = 6;
    localparam int CFG0_PORT_LSB = 2;
    localparam int CFG0_SMODE_LSB = 0;
    localparam logic [7:0] CFG0_WRITABLE = 8'hdf;

    // channel config one fields
    localparam int CFG1_SHARED_BIT = 7;
    localparam int CFG1_GO_ACTIVE_ON_LOOP_BIT = 6;
    localparam int CFG1_GLP_BIT = 5;
    localparam int CFG1_ODS_BIT = 4;
    localparam int CFG1_FILL_BIT = 3;
    localparam int CFG1_CLKMODE_LSB = 0;

    // tx count high fields, same layout on the rx count high read back
    localparam int HIGH_DMA_BIT = 7;
    localparam int HIGH_NRM_BIT = 6;
    localparam int HIGH_CAS_BIT = 5;
    localparam int HIGH_XC_BIT = 4;
    localparam int HIGH_OV_BIT = 4;

    // clock modes that keep the carrier detect pin for their own use
    localparam logic [2:0] CLK_MODE_ONE = 3'h1;
    localparam logic [2:0] CLK_MODE_FIVE = 3'h5;

    // serial port configuration codes
    typedef enum logic [2:0] {
        PORT_NRZ = 3'b000,
        PORT_BUS_T1 = 3'b001,
        PORT_NRZI = 3'b010,
        PORT_BUS_T2 = 3'b011,
        PORT_FM0 = 3'b100,
        PORT_FM1 = 3'b101,
        PORT_MANCH = 3'b110,
        PORT_UNUSED = 3'b111
    } scc_port_e;

    // serial protocol modes
    typedef enum logic [1:0] {
        SMODE_HDLC = 2'b00,
        SMODE_LOOP = 2'b01,
        SMODE_BISYNC = 2'b10,
        SMODE_ASYNC = 2'b11
    } scc_smode_e;

    // sdlc loop states
    typedef enum logic [1:0] {
        LOOP_OFF = 2'b00,
        LOOP_ON = 2'b01,
        LOOP_SENDING = 2'b10
    } scc_loop_e;

    // register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } scc_bus_req_s;

    // decoded line setup handed to the transmitter and receiver
    typedef struct packed {
        scc_port_e port;
        scc_smode_e smode;
        logic bus_mode;
        logic nrz_only;
        logic idle_flags;
        logic one_insert;
        logic shared_flag;
        logic push_pull;
        logic [2:0] clk_mode;
    } scc_line_s;

endpackage : scc_pkg

// ### src/scc_regs.sv
// scc_regs: byte count and channel configuration registers of one serial channel
//
// Summary of operation
// - rx frame length as 12-bit count, two registers
// - low five count bits give rx fifo fill; the code reads back only the length caught at frame end
// - dma frame length is programmed count plus one
// - frame command raises exactly that many dma requests
// - rx count high echoes dma, nrm, cas
// - overflow flag when frame exceeds 4095 bytes
// - transfer bit picks interrupt or dma mode
// - response bit picks full or half duplex in auto mode
// - carrier autostart gates receiver, else general input outside clock modes one and five
// - continuous transmit requests data without count
// - power bit selects standby or active
// - master clock drives access, timers; not everywhere
// - port field selects line coding or bus
// - bus mode forces nrz, and ones idle outside a sending loop
// - serial mode field selects protocol
// - shared flag closes one frame, opens next
// - go active turns seventh one into flag
// - go active cleared repeats rx after closing
// - go on loop adds or drops bit delay
// - idle fill selects ones or flag pattern
// - bus one insertion, never with master clock
`timescale 1ns/1ps
module scc_regs #(
    parameter int CNT_BITS = 12
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // register port
    input scc_pkg::scc_bus_req_s bus_i,
    output logic [7:0] rdata_o,
    // receiver events
    input wire logic rx_byte_i,
    input wire logic rx_frame_end_i,
    input wire logic end_of_poll_i,
    input wire logic carrier_detect_input_i,
    input wire logic auto_mode_i,
    // transmitter events
    input wire logic transmit_frame_cmd_i,
    input wire logic transmit_iframe_cmd_i,
    input wire logic tx_fifo_empty_i,
    input wire logic closing_flag_sent_i,
    // dma handshake
    input wire logic dma_ack_i,
    output logic dma_req_o,
    // channel control outputs
    output scc_pkg::scc_line_s line_o,
    output logic power_up_o,
    output logic dma_mode_o,
    output logic half_duplex_o,
    output logic master_clock_o,
    output logic rx_enable_o,
    output logic carrier_gp_o,
    output logic loop_bit_delay_o,
    output logic loop_repeat_o,
    output logic loop_flag_fill_o,
    output logic seventh_one_zero_o
);
    import scc_pkg::*;

    // software registers
    logic [7:0] cfg0_q;
    logic [7:0] cfg1_q;
    logic [7:0] cfg2_q;
    logic [7:0] tx_low_q;
    logic [7:0] tx_high_q;
    // receive count state
    logic [CNT_BITS-1:0] run_cnt_q;
    logic run_ov_q;
    logic [CNT_BITS-1:0] rx_cnt_q;
    logic rx_ov_q;
    // read path and pin synchroniser
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic cd_meta_q;
    logic cd_sync_q;
    // sdlc loop
    scc_loop_e loop_q;
    scc_loop_e loop_d;
    logic seventh_q;
    // decoded fields
    scc_port_e port;
    scc_smode_e smode;
    logic [2:0] clk_mode;
    logic bus_mode;
    logic loop_mode;
    logic frame_cmd;
    logic [CNT_BITS-1:0] tx_len;

    // a bus port code is one of the two odd codes below the fm0 one
    function automatic logic is_bus(input logic [2:0] code);
        is_bus = (code == PORT_BUS_T1) || (code == PORT_BUS_T2);
    endfunction : is_bus

    // field decode
    assign port = scc_port_e'(cfg0_q[CFG0_PORT_LSB +: 3]);
    assign smode = scc_smode_e'(cfg0_q[CFG0_SMODE_LSB +: 2]);
    assign clk_mode = cfg1_q[CFG1_CLKMODE_LSB +: 3];
    assign bus_mode = is_bus(port);
    assign loop_mode = (smode == SMODE_LOOP);
    assign tx_len = {tx_high_q[CNT_BITS-9:0], tx_low_q};
    assign frame_cmd = transmit_frame_cmd_i || transmit_iframe_cmd_i;

    // configuration writes; count registers share addresses with rx counts
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            cfg0_q <= CFG_RESET;
            cfg1_q <= CFG_RESET;
            cfg2_q <= CFG_RESET;
            tx_low_q <= CFG_RESET;
            tx_high_q <= CFG_RESET;
        end
        else if (bus_i.wr)
        begin
            unique case (bus_i.addr)
                ADDR_BYTE_CNT_LOW: tx_low_q <= bus_i.wdata;
                ADDR_BYTE_CNT_HIGH: tx_high_q <= bus_i.wdata;
                ADDR_CFG_ZERO: cfg0_q <= bus_i.wdata & CFG0_WRITABLE;
                ADDR_CFG_ONE: cfg1_q <= bus_i.wdata;
                ADDR_CFG_TWO: cfg2_q <= bus_i.wdata;
                default: ;
            endcase
        end
    end

    // running count of bytes pushed into the rx fifo for the current frame;
    // a byte that lands with the frame end belongs to the closing frame
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i || rx_frame_end_i)
        begin
            run_cnt_q <= '0;
            run_ov_q <= 1'b0;
        end
        else if (rx_byte_i)
        begin
            run_cnt_q <= run_cnt_q + CNT_BITS'(1);
            if (run_cnt_q == CNT_MAX)
            begin
                run_ov_q <= 1'b1;
            end
        end
    end

    // frame length and overflow caught at message end for the host to read
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            rx_cnt_q <= '0;
            rx_ov_q <= 1'b0;
        end
        else if (rx_frame_end_i)
        begin
            rx_cnt_q <= run_cnt_q + CNT_BITS'(rx_byte_i);
            rx_ov_q <= run_ov_q || (rx_byte_i && (run_cnt_q == CNT_MAX));
        end
    end

    // read multiplexer; write-only halves read as their rx counterparts
    always_comb
    begin
        rdata_d = READ_UNMAPPED;
        unique case (bus_i.addr)
            ADDR_BYTE_CNT_LOW: rdata_d = rx_cnt_q[7:0];
            ADDR_BYTE_CNT_HIGH:
            begin
                rdata_d = {tx_high_q[HIGH_DMA_BIT:HIGH_CAS_BIT], rx_ov_q,
                    rx_cnt_q[CNT_BITS-1:8]};
            end
            ADDR_CFG_ZERO: rdata_d = cfg0_q;
            ADDR_CFG_ONE: rdata_d = cfg1_q;
            ADDR_CFG_TWO: rdata_d = cfg2_q;
            default: rdata_d = READ_UNMAPPED;
        endcase
    end

    // read data stand one cycle after the strobe and are zero otherwise
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i || !bus_i.rd)
        begin
            rdata_q <= READ_UNMAPPED;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end
    assign rdata_o = rdata_q;

    // carrier detect comes straight from a pin, so two flops first
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            cd_meta_q <= 1'b0;
            cd_sync_q <= 1'b0;
        end
        else
        begin
            cd_meta_q <= carrier_detect_input_i;
            cd_sync_q <= cd_meta_q;
        end
    end

    // sdlc loop: every move waits for an end of poll except the drop to off when
    // loop mode is left, and the release, which waits for the fifo to drain and the closing flag to go out
    always_comb
    begin
        loop_d = loop_q;
        unique case (loop_q)
            LOOP_OFF:
            begin
                if (end_of_poll_i && cfg1_q[CFG1_GLP_BIT])
                begin
                    loop_d = LOOP_ON;
                end
            end
            LOOP_ON:
            begin
                if (end_of_poll_i && !cfg1_q[CFG1_GLP_BIT])
                begin
                    loop_d = LOOP_OFF;
                end
                else if (end_of_poll_i && cfg1_q[CFG1_GO_ACTIVE_ON_LOOP_BIT])
                begin
                    loop_d = LOOP_SENDING;
                end
            end
            LOOP_SENDING:
            begin
                if (!cfg1_q[CFG1_GO_ACTIVE_ON_LOOP_BIT] && tx_fifo_empty_i && closing_flag_sent_i)
                begin
                    loop_d = LOOP_ON;
                end
            end
            default: loop_d = LOOP_OFF;
        endcase
        if (!loop_mode)
        begin
            loop_d = LOOP_OFF;
        end
    end

    // loop state register and the one-cycle seventh-bit flip
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            loop_q <= LOOP_OFF;
            seventh_q <= 1'b0;
        end
        else
        begin
            loop_q <= loop_d;
            seventh_q <= (loop_q == LOOP_ON) && (loop_d == LOOP_SENDING);
        end
    end

    // loop outputs; while sending the rx path is cut off from tx
    assign loop_bit_delay_o = (loop_q != LOOP_OFF);
    assign loop_repeat_o = (loop_q == LOOP_ON);
    assign loop_flag_fill_o = (loop_q == LOOP_SENDING);
    assign seventh_one_zero_o = seventh_q;

    // line setup for the serial engines
    always_comb
    begin
        line_o.port = port;
        line_o.smode = smode;
        line_o.bus_mode = bus_mode;
        line_o.nrz_only = bus_mode;
        // bus forces ones idle; a sending loop station always fills flags
        line_o.idle_flags = loop_flag_fill_o ||
            (!bus_mode && cfg1_q[CFG1_FILL_BIT]);
        // insertion would break the master clock timing, so it loses
        line_o.one_insert = bus_mode && cfg1_q[CFG1_FILL_BIT] &&
            !cfg0_q[CFG0_MCE_BIT];
        line_o.shared_flag = cfg1_q[CFG1_SHARED_BIT];
        line_o.push_pull = cfg1_q[CFG1_ODS_BIT];
        line_o.clk_mode = clk_mode;
    end

    // channel controls
    assign power_up_o = cfg0_q[CFG0_POWER_BIT];
    assign dma_mode_o = tx_high_q[HIGH_DMA_BIT];
    assign half_duplex_o = auto_mode_i && tx_high_q[HIGH_NRM_BIT];
    // master clock is refused where it cannot work
    assign master_clock_o = cfg0_q[CFG0_MCE_BIT] && (clk_mode != CLK_MODE_FIVE) &&
        !loop_mode;
    assign rx_enable_o = power_up_o && (!tx_high_q[HIGH_CAS_BIT] || cd_sync_q);
    assign carrier_gp_o = cd_sync_q && !tx_high_q[HIGH_CAS_BIT] &&
        (clk_mode != CLK_MODE_ONE) && (clk_mode != CLK_MODE_FIVE);

    // dma request counter, only alive in dma mode while powered
    scc_dma_req #(
        .CW(CNT_BITS)
    ) u_dma_req (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .enable_i(dma_mode_o && power_up_o),
        .start_i(frame_cmd),
        .cont_i(tx_high_q[HIGH_XC_BIT]),
        .len_i(tx_len),
        .ack_i(dma_ack_i),
        .req_o(dma_req_o)
    );

    // reading rx count low returns the caught frame length next cycle
    cnt_low_read_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (bus_i.rd && bus_i.addr == ADDR_BYTE_CNT_LOW)
        |=> (rdata_o == $past(rx_cnt_q[7:0])))
        else $error("rx count low read wrong");

    // mode bits written high come back on the rx count high read
    mode_echo_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (bus_i.wr && bus_i.addr == ADDR_BYTE_CNT_HIGH) ##1 !bus_i.wr ##1
        (bus_i.rd && bus_i.addr == ADDR_BYTE_CNT_HIGH && !bus_i.wr)
        |=> (rdata_o[7:5] == $past(bus_i.wdata[7:5], 3)))
        else $error("mode bits not echoed");

    // a frame longer than the counter reach raises overflow
    ov_flag_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (rx_frame_end_i && run_ov_q) |=> rx_ov_q)
        else $error("overflow flag missed");

    // bus configurations never idle with flags outside a sending loop
    bus_idle_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (bus_mode && !loop_flag_fill_o) |-> !line_o.idle_flags)
        else $error("bus mode idles with flags");

    // one insertion never coexists with master clock
    oin_mce_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        line_o.one_insert |-> (!cfg0_q[CFG0_MCE_BIT] && bus_mode))
        else $error("one insertion with master clock");

    // going active flips the seventh one exactly once, with flag fill starting in the same cycle
    go_active_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (loop_q == LOOP_ON && end_of_poll_i && cfg1_q[CFG1_GLP_BIT] &&
        cfg1_q[CFG1_GO_ACTIVE_ON_LOOP_BIT] && loop_mode)
        |=> (seventh_one_zero_o && loop_flag_fill_o) ##1 !seventh_one_zero_o)
        else $error("go active sequence wrong");

    // in loop mode, leaving the loop only follows an end of poll with go on loop cleared
    leave_loop_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (loop_q == LOOP_ON && loop_mode && !end_of_poll_i) |=> (loop_q != LOOP_OFF))
        else $error("left loop without end of poll");

    // with autostart the receiver follows the synchronised carrier
    cas_gate_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (tx_high_q[HIGH_CAS_BIT] && power_up_o && !$past(carrier_detect_input_i, 2))
        |-> !rx_enable_o)
        else $error("receiver enabled without carrier");

    // power bit resets low after reset
    power_reset_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        $past(rst_i) |-> (!power_up_o && !dma_req_o))
        else $error("power bit not reset");

endmodule : scc_regs
